/* verilog/ewd_cfg.svh */
`ifndef EWD_CFG_SVH
`define EWD_CFG_SVH

// Register location in A16 space
`define EWD_WIN_OFFSET 16'h0010

// Field positions
`define EWD_RSVD0_BIT 15
`define EWD_EN_BIT 14
`define EWD_DIR_BIT 13
`define EWD_RSVD1_MSB 12
`define EWD_RSVD1_LSB 11
`define EWD_SIZE_MSB 10
`define EWD_SIZE_LSB 8
`define EWD_BASE_MSB 7
`define EWD_BASE_LSB 0

// Byte lanes
`define EWD_LANE_HI 1
`define EWD_LANE_LO 0

// Fixed read values
`define EWD_RSVD0_VAL 1'b0
`define EWD_RSVD1_VAL 2'h3
`define EWD_RD_IDLE 16'h0000

// Compared address lines
`define EWD_ADDR_MSB 31
`define EWD_ADDR_LSB 24

// Hard reset values
`define EWD_EN_RST 1'b0
`define EWD_DIR_RST 1'b0
`define EWD_SIZE_RST 3'h0
`define EWD_BASE_RST 8'h00

// Mask helpers
`define EWD_MASK_NONE 8'h00
`define EWD_MASK_BITS 8

`endif

/* verilog/ewd_pkg.sv */
package ewd_pkg;

    // Window setting
    typedef struct packed {
        logic en;
        logic dir;
        logic [2:0] size;
        logic [7:0] base;
    } ewd_win_s;

    // Upper-byte fields held until the low byte lands
    typedef struct packed {
        logic en;
        logic dir;
        logic [2:0] size;
    } ewd_stage_s;

    // A16 register access
    typedef struct packed {
        logic sel;
        logic wr;
        logic rd;
        logic [15:0] offset;
        logic [1:0] be;
        logic [15:0] wdata;
    } ewd_reg_req_s;

    // A32 access seen on one bus
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } ewd_acc_s;

    // Routing decision for one access
    typedef struct packed {
        logic valid;
        logic own;
        logic fwd;
    } ewd_route_s;

endpackage

/* verilog/ewd_window_decoder.sv */
`timescale 1ns/1ps
`include "ewd_cfg.svh"


module ewd_window_decoder
    import ewd_pkg::*;
(
    sys_clk,
    rst,
    soft_rst,
    compat_layout_bit,
    reg_req,
    reg_rdata,
    reg_ack,
    vme_acc,
    own_vme_hit,
    exp_acc,
    own_exp_hit,
    vme_route,
    exp_route,
    window_cfg
);
    input wire logic sys_clk;
    input wire logic rst;
    input wire logic soft_rst;
    input wire logic compat_layout_bit;
    input wire ewd_reg_req_s reg_req;
    output logic [15:0] reg_rdata;
    output logic reg_ack;
    input wire ewd_acc_s vme_acc;
    input wire logic own_vme_hit;
    input wire ewd_acc_s exp_acc;
    input wire logic own_exp_hit;
    output ewd_route_s vme_route;
    output ewd_route_s exp_route;
    output ewd_win_s window_cfg;

    // Mask of compared base bits, MSB first
    function automatic logic [7:0] size_mask(input logic [2:0] size);
        logic [7:0] m;
        m = `EWD_MASK_NONE;
        for (int i = 0; i < `EWD_MASK_BITS; i++) begin
            if (i < int'(size)) begin
                m[`EWD_BASE_MSB - i] = 1'b1;
            end
        end
        return m;
    endfunction

    // True when the address falls in the programmed range
    function automatic logic in_window(
        input logic [31:0] addr,
        input ewd_win_s w
    );
        logic [7:0] diff;
        diff = addr[`EWD_ADDR_MSB:`EWD_ADDR_LSB] ^ w.base;
        return (diff & size_mask(w.size)) == `EWD_MASK_NONE;
    endfunction

    // Routing for one access; inward picks the sense of the range
    function automatic ewd_route_s route(
        input ewd_acc_s acc,
        input logic own,
        input ewd_win_s w,
        input logic inward
    );
        ewd_route_s r;
        logic hit;
        logic sel;
        hit = in_window(acc.addr, w);
        sel = inward ? w.dir : ~w.dir;
        r.valid = acc.valid;
        r.own = acc.valid & own;
        r.fwd = acc.valid & ~own & w.en & (hit == sel);
        return r;
    endfunction

    ewd_stage_s stage_q;
    ewd_stage_s stage_d;
    ewd_win_s active_q;
    ewd_win_s active_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic ack_q;
    logic ack_d;
    ewd_route_s vme_route_q;
    ewd_route_s vme_route_d;
    ewd_route_s exp_route_q;
    ewd_route_s exp_route_d;

    logic reg_hit;
    logic wr_hi;
    logic wr_lo;

    // Register decode
    always_comb begin
        reg_hit = reg_req.sel & ~compat_layout_bit &
            (reg_req.offset == `EWD_WIN_OFFSET);
        wr_hi = reg_hit & reg_req.wr & reg_req.be[`EWD_LANE_HI];
        wr_lo = reg_hit & reg_req.wr & reg_req.be[`EWD_LANE_LO];
    end

    // Setting state next values
    always_comb begin
        stage_d = stage_q;
        active_d = active_q;
        if (wr_hi) begin
            stage_d.en = reg_req.wdata[`EWD_EN_BIT];
            stage_d.dir = reg_req.wdata[`EWD_DIR_BIT];
            stage_d.size =
                reg_req.wdata[`EWD_SIZE_MSB:`EWD_SIZE_LSB];
        end
        if (wr_lo) begin
            active_d.en = stage_d.en;
            active_d.dir = stage_d.dir;
            active_d.size = stage_d.size;
            active_d.base =
                reg_req.wdata[`EWD_BASE_MSB:`EWD_BASE_LSB];
        end
    end

    // Setting state registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stage_q.en <= `EWD_EN_RST;
            stage_q.dir <= `EWD_DIR_RST;
            stage_q.size <= `EWD_SIZE_RST;
            active_q.en <= `EWD_EN_RST;
            active_q.dir <= `EWD_DIR_RST;
            active_q.size <= `EWD_SIZE_RST;
            active_q.base <= `EWD_BASE_RST;
        end else begin
            stage_q <= stage_d;
            active_q <= active_d;
        end
    end

    // Read data and acknowledge next values
    always_comb begin
        rdata_d = `EWD_RD_IDLE;
        ack_d = 1'b0;
        if (reg_hit && (reg_req.rd || reg_req.wr)) begin
            ack_d = 1'b1;
        end
        if (reg_hit && reg_req.rd) begin
            rdata_d[`EWD_RSVD0_BIT] = `EWD_RSVD0_VAL;
            rdata_d[`EWD_EN_BIT] = stage_q.en;
            rdata_d[`EWD_DIR_BIT] = stage_q.dir;
            rdata_d[`EWD_RSVD1_MSB:`EWD_RSVD1_LSB] = `EWD_RSVD1_VAL;
            rdata_d[`EWD_SIZE_MSB:`EWD_SIZE_LSB] = stage_q.size;
            rdata_d[`EWD_BASE_MSB:`EWD_BASE_LSB] = active_q.base;
        end
    end

    // Read data and acknowledge registers
    always_ff @(posedge sys_clk) begin
        if (rst || soft_rst) begin
            rdata_q <= `EWD_RD_IDLE;
            ack_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            ack_q <= ack_d;
        end
    end

    // Routing next values
    always_comb begin
        vme_route_d = route(vme_acc, own_vme_hit, active_q, 1'b0);
        exp_route_d = route(exp_acc, own_exp_hit, active_q, 1'b1);
        if (soft_rst) begin
            vme_route_d = '0;
            exp_route_d = '0;
        end
    end

    // Routing registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            vme_route_q <= '0;
            exp_route_q <= '0;
        end else begin
            vme_route_q <= vme_route_d;
            exp_route_q <= exp_route_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_ack = ack_q;
    assign vme_route = vme_route_q;
    assign exp_route = exp_route_q;
    assign window_cfg = active_q;

endmodule // ewd_window_decoder

/* verif/ewd_masters.sv */
`timescale 1ns/1ps
module ewd_masters
    import ewd_pkg::*;
(
    input wire logic go,
    input wire logic [31:0] addr,
    input wire logic own,
    output ewd_acc_s vme_acc,
    output logic own_vme_hit,
    output ewd_acc_s exp_acc,
    output logic own_exp_hit
);
    // Idle bus shows inverted address
    assign vme_acc = '{go, go ? addr : ~addr};
    assign exp_acc = vme_acc;
    assign own_vme_hit = go & own;
    assign own_exp_hit = own_vme_hit;
endmodule // ewd_masters

/* verif/ewd_properties.sv */
`timescale 1ns/1ps
module ewd_properties
    import ewd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic soft_rst,
    input wire logic compat_layout_bit,
    input wire ewd_reg_req_s reg_req,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_ack,
    input wire ewd_acc_s vme_acc,
    input wire logic own_vme_hit,
    input wire ewd_acc_s exp_acc,
    input wire logic own_exp_hit,
    input wire ewd_route_s vme_route,
    input wire ewd_route_s exp_route,
    input wire ewd_win_s window_cfg
);
    logic [7:0] mask;
    logic vhit;
    logic ehit;
    logic take;
    always_comb begin
        mask = ~(8'hFF >> window_cfg.size);
        vhit = ((vme_acc.addr[31:24] ^ window_cfg.base) & mask) == 8'h00;
        ehit = ((exp_acc.addr[31:24] ^ window_cfg.base) & mask) == 8'h00;
        take = reg_req.sel && reg_req.offset == 16'h0010 && !soft_rst
            && !compat_layout_bit && (reg_req.rd || reg_req.wr);
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    ack_on_take_a: assert property (take |=> reg_ack)
        else $error("register ack missing");
    no_stray_ack_a: assert property (!take |=> !reg_ack)
        else $error("unexpected register ack");
    fixed_bits_a: assert property (
        reg_ack && $past(reg_req.rd) |-> !reg_rdata[15]
            && reg_rdata[12:11] == 2'h3) else $error("fixed bits wrong");
    upper_only_a: assert property (
        take && reg_req.wr && reg_req.be == 2'h2 |=> $stable(window_cfg))
        else $error("window changed on upper byte");
    own_wins_a: assert property (
        vme_acc.valid && own_vme_hit && !soft_rst
            |=> vme_route.own && !vme_route.fwd) else $error("own lost");
    vme_fwd_a: assert property (
        vme_acc.valid && !own_vme_hit && !soft_rst |=> vme_route.fwd ==
            $past(window_cfg.en && vhit != window_cfg.dir))
        else $error("outward forward wrong");
    exp_fwd_a: assert property (
        exp_acc.valid && !own_exp_hit && !soft_rst |=> exp_route.fwd ==
            $past(window_cfg.en && ehit == window_cfg.dir))
        else $error("inward forward wrong");
    hard_clear_a: assert property ($fell(rst) |-> window_cfg == '0)
        else $error("hard reset left window");
    soft_keep_a: assert property (
        soft_rst && !reg_req.wr |=> $stable(window_cfg))
        else $error("soft reset changed window");
endmodule // ewd_properties

bind ewd_window_decoder ewd_properties u_props (.sys_clk(sys_clk),
    .rst(rst), .soft_rst(soft_rst), .compat_layout_bit(compat_layout_bit),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .vme_acc(vme_acc), .own_vme_hit(own_vme_hit), .exp_acc(exp_acc),
    .own_exp_hit(own_exp_hit), .vme_route(vme_route),
    .exp_route(exp_route), .window_cfg(window_cfg));

/* verif/test_extender_a32_window_decoder.sv */
`timescale 1ns/1ps
module test_extender_a32_window_decoder
    import ewd_pkg::*;
;
    logic sys_clk = 0, rst = 1, soft_rst = 0, compat = 0;
    logic go = 0, own = 0, ack, vown, eown;
    logic [31:0] addr = 0;
    logic [15:0] rdata;
    ewd_reg_req_s req = '0;
    ewd_acc_s vacc, eacc;
    ewd_route_s vr, er;
    ewd_win_s cfg;
    int mismatches = 0, comparisons = 0, cyc = 0;
    always #2 sys_clk = ~sys_clk;
    ewd_window_decoder dut (.sys_clk(sys_clk), .rst(rst),
        .soft_rst(soft_rst), .compat_layout_bit(compat), .reg_req(req),
        .reg_rdata(rdata), .reg_ack(ack), .vme_acc(vacc),
        .own_vme_hit(vown), .exp_acc(eacc), .own_exp_hit(eown),
        .vme_route(vr), .exp_route(er), .window_cfg(cfg));
    ewd_masters far (.go(go), .addr(addr), .own(own), .vme_acc(vacc),
        .own_vme_hit(vown), .exp_acc(eacc), .own_exp_hit(eown));
    task chk(string n, logic [15:0] e, logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task regop(logic [15:0] off, logic wr, logic [1:0] be,
        logic [15:0] wd, logic a, logic [15:0] rd);
        @(negedge sys_clk);
        req = '{1'b1, wr, !wr, off, be, wd};
        @(negedge sys_clk);
        req = '0;
        chk("ack", a, ack);
        if (!wr)
            chk("rdata", rd, rdata);
    endtask
    task route(logic [31:0] a, logic o, logic v, logic e);
        @(negedge sys_clk);
        go = 1;
        addr = a;
        own = o;
        @(negedge sys_clk);
        go = 0;
        chk("vme_route", {1'b1, o, v}, vr);
        chk("exp_route", {1'b1, o, e}, er);
    endtask
    task summarize;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 2000) begin
            mismatches++;
            summarize;
        end
    end
    initial begin
        repeat (6) @(negedge sys_clk);
        rst = 0;
        regop(16'h0010, 0, 2'h3, 0, 1, 16'h1800);
        regop(16'h0010, 1, 2'h2, 16'hE300, 1, 0);
        chk("cfg", 0, cfg);
        regop(16'h0010, 0, 2'h3, 0, 1, 16'h7B00);
        regop(16'h0010, 1, 2'h1, 16'h0080, 1, 0);
        chk("cfg", ewd_win_s'{1'b1, 1'b1, 3'h3, 8'h80}, cfg);
        regop(16'h0010, 0, 2'h3, 0, 1, 16'h7B80);
        $display("register test done");
        route(32'h9F000000, 0, 0, 1);
        route(32'hA0000000, 0, 1, 0);
        route(32'h80FFFFFF, 1, 0, 0);
        route(32'h7FFFFFFF, 0, 1, 0);
        regop(16'h0010, 1, 2'h3, 16'h4780, 1, 0);
        route(32'h81000000, 0, 1, 0);
        route(32'h82000000, 0, 0, 1);
        regop(16'h0010, 1, 2'h3, 16'h4000, 1, 0);
        route(32'h12345678, 0, 1, 0);
        regop(16'h0010, 1, 2'h3, 16'h0380, 1, 0);
        route(32'h80000000, 0, 0, 0);
        $display("route test done");
        @(negedge sys_clk);
        soft_rst = 1;
        @(negedge sys_clk);
        soft_rst = 0;
        chk("cfg", ewd_win_s'{1'b0, 1'b0, 3'h3, 8'h80}, cfg);
        regop(16'h0012, 0, 2'h3, 0, 0, 0);
        compat = 1;
        regop(16'h0010, 1, 2'h3, 16'h4000, 0, 0);
        compat = 0;
        chk("cfg", ewd_win_s'{1'b0, 1'b0, 3'h3, 8'h80}, cfg);
        rst = 1;
        @(negedge sys_clk);
        rst = 0;
        chk("cfg", 0, cfg);
        $display("reset test done");
        summarize;
    end
endmodule // test_extender_a32_window_decoder
